// ===== common/pdm_pkg.sv
// Package with the register map, reset values and widths of the port drive and match block
package pdm_pkg;
  localparam int unsigned PDM_PORT_W = 8;
  localparam int unsigned PDM_ADDR_W = 8;
  localparam int unsigned PDM_PAGE_W = 4;
  // Special-function page holding all three registers
  localparam logic [3:0] PDM_CFG_PAGE = 4'hF;
  // Register addresses
  localparam logic [7:0] PDM_ADDR_CMP_EN    = 8'h8C;
  localparam logic [7:0] PDM_ADDR_DRIVE_SEL = 8'h99;
  localparam logic [7:0] PDM_ADDR_EXP_LVL   = 8'hF5;
  // Reset values
  localparam logic [7:0] PDM_RST_CMP_EN    = 8'h00;
  localparam logic [7:0] PDM_RST_DRIVE_SEL = 8'h00;
  localparam logic [7:0] PDM_RST_EXP_LVL   = 8'hFF;
  localparam logic [7:0] PDM_RD_IDLE       = 8'h00;
  // Pin synchroniser constants
  localparam logic [2:0] PDM_SYNC_RST = 3'h0;
endpackage

// ===== common/pdm_sfr_if.sv
// Interface carrying the decoded register write strobes and data to the register file
`timescale 1ns/1ps
interface pdm_sfr_if;
  import pdm_pkg::*;
  logic                  wr_drive_sel;
  logic                  wr_cmp_en;
  logic                  wr_exp_lvl;
  logic [PDM_PORT_W-1:0] wdata;
  logic [PDM_PORT_W-1:0] drive_sel;
  logic [PDM_PORT_W-1:0] cmp_en;
  logic [PDM_PORT_W-1:0] exp_lvl;
  modport dec (output wr_drive_sel, output wr_cmp_en, output wr_exp_lvl, output wdata,
               input drive_sel, input cmp_en, input exp_lvl);
  modport regs (input wr_drive_sel, input wr_cmp_en, input wr_exp_lvl, input wdata,
                output drive_sel, output cmp_en, output exp_lvl);
endinterface

// ===== rtl/pdm_regs.sv
// Register file holding the three configuration registers
`timescale 1ns/1ps
module pdm_regs
  import pdm_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic nrst_in,
  pdm_sfr_if.regs   sfr
);
  logic [PDM_PORT_W-1:0] drive_sel_reg;
  logic [PDM_PORT_W-1:0] cmp_en_reg;
  logic [PDM_PORT_W-1:0] exp_lvl_reg;

  // Drive strength select, cleared at reset
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drive_sel_reg <= PDM_RST_DRIVE_SEL;
    end else if (sfr.wr_drive_sel) begin
      drive_sel_reg <= sfr.wdata;
    end
  end

  // Compare enables, cleared so no pin is compared after reset
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmp_en_reg <= PDM_RST_CMP_EN;
    end else if (sfr.wr_cmp_en) begin
      cmp_en_reg <= sfr.wdata;
    end
  end

  // Expected levels, all high after reset
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      exp_lvl_reg <= PDM_RST_EXP_LVL;
    end else if (sfr.wr_exp_lvl) begin
      exp_lvl_reg <= sfr.wdata;
    end
  end

  assign sfr.drive_sel = drive_sel_reg;
  assign sfr.cmp_en    = cmp_en_reg;
  assign sfr.exp_lvl   = exp_lvl_reg;
endmodule

// ===== rtl/pdm_port_drive_match.sv
// Top of the port drive strength and port mismatch block
// Operation
// - Port 0 pin drive is low strength for bit 0, high for bit 1.
// - Drive select register at page 0xF address 0x99, read-write, resets to zero.
// - Compare-enable bit 0 means that pin never causes a mismatch.
// - Compare-enable bit 1 compares the pin with its expected level bit.
// - Expected level bit 0 expects low, bit 1 expects high.
// - Compare-enable register at page 0xF address 0x8C, resets to zero.
// - Expected level register at page 0xF address 0xF5, resets to all ones.
`timescale 1ns/1ps
module pdm_port_drive_match
  import pdm_pkg::*;
(
  input  wire logic                  core_clk_in,
  input  wire logic                  nrst_in,
  input  wire logic [PDM_PAGE_W-1:0] sfr_page_in,
  input  wire logic [PDM_ADDR_W-1:0] sfr_addr_in,
  input  wire logic                  sfr_wr_in,
  input  wire logic                  sfr_rd_in,
  input  wire logic [PDM_PORT_W-1:0] sfr_wdata_in,
  input  wire logic [PDM_PORT_W-1:0] port1_pin_in,
  output logic      [PDM_PORT_W-1:0] sfr_rdata_out,
  output logic                       sfr_hit_out,
  output logic      [PDM_PORT_W-1:0] port0_high_drive_out,
  output logic                       port1_mismatch_out
);
  pdm_sfr_if sfr ();

  // Data path in brief. Register writes are decoded here and land in the
  // register file at the edge that carries the strobe; the drive select is
  // copied to the pads one edge later. Port 1 pins pass a three-stage
  // synchroniser and an agree filter, are compared pin by pin with the
  // expected levels under the compare enables, and the OR of the per-pin
  // terms is registered as the mismatch event. Reads are registered as well,
  // so the answer stands in the cycle after the read strobe.
  // Limitation: the event is a plain level and nothing here latches it; a
  // pin pulse of a single cycle never gets through the filter at all.

  // Address decode shared by the write and read paths. The page has to match
  // too: other blocks reuse these addresses on their own pages, and a bare
  // address compare would let their writes land here.
  // Kept as a function so all three uses decode in exactly the same way.
  function automatic logic sel(input logic [PDM_PAGE_W-1:0] pg,
                               input logic [PDM_ADDR_W-1:0] ad,
                               input logic [PDM_ADDR_W-1:0] target);
    sel = (pg == PDM_CFG_PAGE) && (ad == target);
  endfunction

  // Per-pin compare term: a pin counts only when enabled and off its level
  function automatic logic pin_off(input logic en,
                                   input logic lvl,
                                   input logic exp);
    pin_off = en && (lvl != exp);
  endfunction

  // Bus timing: an access is taken at the rising edge where its strobe is
  // high. Writes land at that edge; reads answer after it. Back-to-back
  // accesses need no gap, and a read in the cycle of a write to the same
  // register returns the old value because the register updates at the edge.
  // Decoded register selects, shared by the write strobes and the read mux
  logic hit_drive_sel;
  logic hit_cmp_en;
  logic hit_exp_lvl;

  assign hit_drive_sel = sel(sfr_page_in, sfr_addr_in, PDM_ADDR_DRIVE_SEL);
  assign hit_cmp_en    = sel(sfr_page_in, sfr_addr_in, PDM_ADDR_CMP_EN);
  assign hit_exp_lvl   = sel(sfr_page_in, sfr_addr_in, PDM_ADDR_EXP_LVL);

  // Write strobes; a strobe held high just rewrites the same value
  assign sfr.wr_drive_sel = sfr_wr_in && hit_drive_sel;
  assign sfr.wr_cmp_en    = sfr_wr_in && hit_cmp_en;
  assign sfr.wr_exp_lvl   = sfr_wr_in && hit_exp_lvl;
  assign sfr.wdata        = sfr_wdata_in;

  // The register file sees decoded strobes only, never the raw bus
  pdm_regs u_regs (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .sfr         (sfr.regs)
  );

  // Pins are asynchronous: three stages, a change counts once stages two
  // and three agree. Every stage starts at the all-high level that the
  // filtered level starts at, so the filter sees no false step after reset.
  logic [PDM_PORT_W-1:0] p1_s1_reg;
  logic [PDM_PORT_W-1:0] p1_s2_reg;
  logic [PDM_PORT_W-1:0] p1_s3_reg;
  logic [PDM_PORT_W-1:0] p1_lvl_reg;
  logic [PDM_PORT_W-1:0] p1_settled;

  // First stage may go metastable; only stage two reads it
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      p1_s1_reg <= PDM_RST_EXP_LVL;
    end else begin
      p1_s1_reg <= port1_pin_in;
    end
  end

  // Second stage, the first one that the rest of the logic may look at;
  // it feeds both the third stage and the agree test
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      p1_s2_reg <= PDM_RST_EXP_LVL;
    end else begin
      p1_s2_reg <= p1_s1_reg;
    end
  end

  // Third stage, compared with the second and loaded into the filtered level
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      p1_s3_reg <= PDM_RST_EXP_LVL;
    end else begin
      p1_s3_reg <= p1_s2_reg;
    end
  end

  // A bit is settled once stages two and three hold the same level
  assign p1_settled = ~(p1_s2_reg ^ p1_s3_reg);

  // Per-bit filter: a level still moving through stage two is held back,
  // which costs a cycle on each edge but keeps a pin that sits near its
  // threshold from toggling the event every cycle.
  genvar gi;
  generate
    for (gi = 0; gi < PDM_PORT_W; gi++) begin : g_filt
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          p1_lvl_reg[gi] <= PDM_RST_EXP_LVL[gi];
        end else if (p1_settled[gi]) begin
          p1_lvl_reg[gi] <= p1_s3_reg[gi];
        end
      end
    end
  endgenerate

  // Per-pin compare: masked-out pins drop out, enabled pins compare with
  // their expected level. Compare enables reset to zero, so straight after
  // reset no pin can raise the event whatever the board drives, and the
  // expected levels default high.
  logic [PDM_PORT_W-1:0] diff;
  genvar gj;
  generate
    for (gj = 0; gj < PDM_PORT_W; gj++) begin : g_cmp
      assign diff[gj] = pin_off(sfr.cmp_en[gj],
                                p1_lvl_reg[gj],
                                sfr.exp_lvl[gj]);
    end
  endgenerate

  // Event: high while any enabled pin is off its expected level. It is
  // registered so the wake-up logic outside never sees the glitches of the
  // wide OR when several registers or pins change in one cycle.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port1_mismatch_out <= 1'b0;
    end else begin
      port1_mismatch_out <= |diff;
    end
  end

  // Drive strength goes to the pads from a flop, one cycle after the
  // register; the pads see a clean level with no decode glitches on it
  genvar gk;
  generate
    for (gk = 0; gk < PDM_PORT_W; gk++) begin : g_drv
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          port0_high_drive_out[gk] <= PDM_RST_DRIVE_SEL[gk];
        end else begin
          port0_high_drive_out[gk] <= sfr.drive_sel[gk];
        end
      end
    end
  endgenerate

  // Read mux: at most one source, since the three selects are exclusive;
  // unmapped addresses and idle cycles read zero
  logic [PDM_PORT_W-1:0] rdata_next;
  logic                  hit_next;

  always_comb begin
    rdata_next = PDM_RD_IDLE;
    hit_next   = 1'b0;
    if (sfr_rd_in && hit_drive_sel) begin
      rdata_next = sfr.drive_sel;
      hit_next   = 1'b1;
    end else if (sfr_rd_in && hit_cmp_en) begin
      rdata_next = sfr.cmp_en;
      hit_next   = 1'b1;
    end else if (sfr_rd_in && hit_exp_lvl) begin
      rdata_next = sfr.exp_lvl;
      hit_next   = 1'b1;
    end
  end

  // Registered read data; stands for one cycle per read strobe cycle and
  // drops back to zero when the strobe goes away
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_rdata_out <= PDM_RD_IDLE;
    end else begin
      sfr_rdata_out <= rdata_next;
    end
  end

  // Hit flag, so software can tell an unmapped read from a register at zero
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_hit_out <= 1'b0;
    end else begin
      sfr_hit_out <= hit_next;
    end
  end

  // For integration: the pads read port0_high_drive_out directly, and the
  // wake-up and interrupt logic that consumes the event sits outside this
  // block. Both see flop outputs only, so neither can catch a decode
  // glitch, at the price of one cycle of latency on each path.
endmodule

// ===== verif/pdm_pins.sv
// Board model for the Port 1 pins
`timescale 1ns/1ps
module pdm_pins (
  input  wire logic [7:0] lvl_in,
  output logic      [7:0] pin_out
);
  // Pins settle just after the board moves them, never on a clock edge
  assign #1 pin_out = lvl_in;
endmodule

// ===== verif/pdm_chk_sva.sv
// Checker for register access and port outputs
`timescale 1ns/1ps
module pdm_chk (
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic [3:0] sfr_page_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       sfr_hit_out,
  input wire logic [7:0] port0_high_drive_out,
  input wire logic       port1_mismatch_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // Decode helpers; a read in a write cycle sees the old value
  wire pg = sfr_page_in == 4'hF;
  wire dw = sfr_wr_in && pg && sfr_addr_in == 8'h99;
  wire hm = sfr_rd_in && pg && (sfr_addr_in inside {8'h8C, 8'h99, 8'hF5});
  sequence s_cw; sfr_wr_in && pg && sfr_addr_in == 8'h8C; endsequence
  sequence s_cr; sfr_rd_in && !sfr_wr_in && pg && sfr_addr_in == 8'h8C; endsequence
  property p_hit; hm |=> sfr_hit_out; endproperty
  a_hit: assert property (p_hit) else $error("no hit");
  property p_miss; !hm |=> !sfr_hit_out && sfr_rdata_out == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("stray answer");
  property p_dwr; dw |-> ##2 port0_high_drive_out == $past(sfr_wdata_in, 2); endproperty
  a_dwr: assert property (p_dwr) else $error("drive not set");
  property p_dhold; !dw |-> ##2 $stable(port0_high_drive_out); endproperty
  a_dhold: assert property (p_dhold) else $error("drive moved");
  property p_rdrv;
    hm && sfr_addr_in == 8'h99 |=> sfr_rdata_out == port0_high_drive_out;
  endproperty
  a_rdrv: assert property (p_rdrv) else $error("drive readback");
  property p_wrd; s_cw ##1 s_cr |=> sfr_rdata_out == $past(sfr_wdata_in, 2); endproperty
  a_wrd: assert property (p_wrd) else $error("enable readback");
  property p_cause; sfr_hit_out |-> $past(sfr_rd_in); endproperty
  a_cause: assert property (p_cause) else $error("hit without read");
  property p_mm;
    ($stable(port1_pin_in) && !sfr_wr_in)[*6] |=> $stable(port1_mismatch_out);
  endproperty
  a_mm: assert property (p_mm) else $error("mismatch moved");
endmodule
bind pdm_port_drive_match pdm_chk u_chk (.*);

// ===== verif/pdm_port_drive_match_bench.sv
// Bench for the port drive and match block
`timescale 1ns/1ps
module pdm_port_drive_match_bench;
  logic        core_clk_in = 1'h0, nrst_in = 1'h0, sfr_wr_in = 1'h0, sfr_rd_in = 1'h0, e;
  logic        sfr_hit_out, port1_mismatch_out;
  logic [3:0]  sfr_page_in = 4'hF;
  logic [7:0]  sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, lvl = 8'hFF, port1_pin_in;
  logic [7:0]  sfr_rdata_out, port0_high_drive_out;
  // Mask, expected level, pin level
  logic [23:0] tbl [8] = '{24'h00FF00, 24'h01FF00, 24'h01FE00, 24'h81FE00,
                           24'h81FE80, 24'h817E80, 24'hFF7E7E, 24'hFF7E7F};
  int          num_errors = 0, n_tests = 0;
  pdm_pins brd (.lvl_in(lvl), .pin_out(port1_pin_in));
  pdm_port_drive_match dut (.*);
  initial forever #2 core_clk_in = ~core_clk_in;
  // Hang guard
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
  task automatic chk(input string nm, input logic [7:0] got, x);
    n_tests++;
    if (got !== x) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, got);
    end
  endtask
  // Strobes stay up so back-to-back accesses need no gap
  task automatic acc(input logic w, input logic [7:0] a, d);
    sfr_wr_in = w;
    sfr_rd_in = !w;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    @(negedge core_clk_in);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, x, input logic h);
    acc(1'h0, a, 8'h00);
    chk(nm, sfr_rdata_out, x);
    chk("hit", {7'h00, sfr_hit_out}, {7'h00, h});
  endtask
  task automatic idle(input int n);
    sfr_wr_in = 1'h0;
    sfr_rd_in = 1'h0;
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk_in);
    nrst_in = 1'h1;
    @(negedge core_clk_in);
    rdc("drive_sel", 8'h99, 8'h00, 1'h1);
    rdc("cmp_en", 8'h8C, 8'h00, 1'h1);
    rdc("exp_lvl", 8'hF5, 8'hFF, 1'h1);
    $display("reset test done");
    acc(1'h1, 8'h99, 8'hA5);
    acc(1'h1, 8'h99, 8'h5A);
    rdc("drive_sel", 8'h99, 8'h5A, 1'h1);
    sfr_page_in = 4'h0;
    acc(1'h1, 8'h99, 8'hFF);
    rdc("off_page", 8'h99, 8'h00, 1'h0);
    sfr_page_in = 4'hF;
    rdc("unmapped", 8'h98, 8'h00, 1'h0);
    idle(2);
    chk("drive_out", port0_high_drive_out, 8'h5A);
    $display("drive test done");
    // Each step rewrites both registers, then lets the pins settle
    foreach (tbl[i]) begin
      acc(1'h1, 8'hF5, tbl[i][15:8]);
      acc(1'h1, 8'h8C, tbl[i][23:16]);
      rdc("cmp_en", 8'h8C, tbl[i][23:16], 1'h1);
      rdc("exp_lvl", 8'hF5, tbl[i][15:8], 1'h1);
      lvl = tbl[i][7:0];
      e = |((lvl ^ tbl[i][15:8]) & tbl[i][23:16]);
      idle(8);
      chk("mismatch", {7'h00, port1_mismatch_out}, {7'h00, e});
    end
    $display("match test done");
    // Mid-run reset: outputs drop at once and registers return to defaults
    acc(1'h1, 8'h99, 8'hFF);
    acc(1'h1, 8'h8C, 8'hFF);
    idle(2);
    chk("drive_out", port0_high_drive_out, 8'hFF);
    chk("mm_set", {7'h00, port1_mismatch_out}, 8'h01);
    nrst_in = 1'h0;
    idle(2);
    chk("drive_rst", port0_high_drive_out, 8'h00);
    chk("mm_rst", {7'h00, port1_mismatch_out}, 8'h00);
    nrst_in = 1'h1;
    @(negedge core_clk_in);
    rdc("drive_sel", 8'h99, 8'h00, 1'h1);
    rdc("cmp_en", 8'h8C, 8'h00, 1'h1);
    rdc("exp_lvl", 8'hF5, 8'hFF, 1'h1);
    idle(8);
    chk("mm_after", {7'h00, port1_mismatch_out}, 8'h00);
    $display("rerun reset test done");
    close_out;
  end
endmodule
